// ### tape_check_top.sv
// Check accumulators, record check bytes and sense bits of the tape data path
// Functional notes
// - record check fails to s3b3, residue to s9b3
// - channel bytes into buffer fold input accumulator
// - buffer bytes to writer fold output accumulator
// - buffer empty compares; mismatch sets s3b7, s9b2
// - 6250 write records residue, folds it into check
// - PE computes residue but never records it
// - NRZI9 check byte built from data only
// - 6250 readback captures residue, compares output accumulator
// - 6250 read check over all bytes, match
// - PE/NRZI9 forward read data accumulator versus output accumulator
// - NRZI9 read check over data plus check byte
// - forward read feeds buffer and both accumulators
// - 6250 backward read checks in reverse order
// - backward read data accumulator matches pattern
// - seven-track NRZI does no checks at all
// - one group check character per 6250 group
`timescale 1ns/100ps
`include "tape_check_consts.svh"
module tape_check_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rec_start,
  input wire logic buf_in_valid,
  input wire logic [7:0] buf_in_byte,
  input wire logic buf_out_valid,
  input wire logic [7:0] buf_out_byte,
  input wire logic buf_empty,
  input wire logic grp_end,
  input wire logic wr_close,
  input wire tape_check_pkg::tape_byte_t tape_in,
  input wire logic rec_end,
  output logic [7:0] residue_byte,
  output logic residue_valid,
  output logic residue_record,
  output logic [7:0] check_byte,
  output logic check_valid,
  output logic [7:0] group_check_character,
  output logic group_check_valid,
  output tape_check_pkg::sense_t sense,
  output logic irq
);
  // ****************************************
  // Register bus
  // ****************************************
  logic [3:0] ctrl_q;
  logic [2:0] status_q;
  logic [2:0] irq_en_q;
  logic aw_held_q;
  logic [7:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire wr_ctrl = do_write && aw_addr_q == `TC_ADDR_CTRL && w_strb_q[0];
  wire wr_clr = do_write && aw_addr_q == `TC_ADDR_IRQ_CLR && w_strb_q[0];
  wire wr_en = do_write && aw_addr_q == `TC_ADDR_IRQ_EN && w_strb_q[0];
  wire wr_hit = aw_addr_q == `TC_ADDR_CTRL || aw_addr_q == `TC_ADDR_IRQ_CLR ||
                aw_addr_q == `TC_ADDR_IRQ_EN;
  wire [2:0] clr_bits = wr_clr ? w_data_q[2:0] : 3'h0;
  wire do_read = arvalid && arready;
  wire rd_hit = araddr == `TC_ADDR_CTRL || araddr == `TC_ADDR_STATUS ||
                araddr == `TC_ADDR_IRQ_CLR || araddr == `TC_ADDR_IRQ_EN ||
                araddr == `TC_ADDR_ACCUM;

  assign awready = !aw_held_q;
  assign wready = !w_held_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `TC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Mode and operation control
  // ****************************************
  tape_check_pkg::mode_t mode;
  tape_check_pkg::op_t op;
  assign mode = tape_check_pkg::mode_t'(ctrl_q[`TC_CTRL_MODE_LSB +: 2]);
  assign op = tape_check_pkg::op_t'(ctrl_q[`TC_CTRL_OP_LSB +: 2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `TC_CTRL_RESET;
      irq_en_q <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= w_data_q[3:0];
      end
      if (wr_en) begin
        irq_en_q <= w_data_q[2:0];
      end
    end
  end

  wire is_6250 = mode == tape_check_pkg::MODE_6250;
  wire is_pe = mode == tape_check_pkg::MODE_PE;
  wire is_nrzi9 = mode == tape_check_pkg::MODE_NRZI9;
  wire active = mode != tape_check_pkg::MODE_NRZI7;
  wire is_write = op == tape_check_pkg::OP_WRITE;
  wire is_bwd = op == tape_check_pkg::OP_READ_BWD;

  // ****************************************
  // Accumulators
  // ****************************************
  logic [7:0] acc_in;
  logic [7:0] acc_out;
  logic [7:0] acc_wr;
  logic [7:0] acc_rd;
  logic [7:0] acc_rb;
  logic [7:0] res_rd_q;

  wire fold_res = wr_close && is_write && is_6250;
  wire fold_in = buf_in_valid && active;
  wire fold_out = buf_out_valid && active;
  wire fold_wr = (buf_out_valid && is_write && (is_6250 || is_nrzi9)) || fold_res;
  wire [7:0] wr_din = fold_res ? acc_in : buf_out_byte;
  wire tape_data = tape_in.valid && tape_in.kind == tape_check_pkg::KIND_DATA;
  wire tape_chk = tape_in.valid && tape_in.kind == tape_check_pkg::KIND_CHECK;
  wire tape_res = tape_in.valid && tape_in.kind == tape_check_pkg::KIND_RESIDUE;
  wire fold_rd = (tape_in.valid && is_6250) || ((tape_data || tape_chk) && is_nrzi9);
  wire fold_rb = (is_pe || is_nrzi9) && (tape_data || (tape_chk && is_bwd));

  // Input side
  check_accum u_acc_in (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(rec_start),
    .fold(fold_in),
    .rev(is_bwd),
    .din(buf_in_byte),
    .acc(acc_in)
  );

  // Output side
  check_accum u_acc_out (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(rec_start),
    .fold(fold_out),
    .rev(is_bwd),
    .din(buf_out_byte),
    .acc(acc_out)
  );

  // Write check generator
  check_accum u_acc_wr (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(rec_start),
    .fold(fold_wr),
    .rev(1'b0),
    .din(wr_din),
    .acc(acc_wr)
  );

  // Read check
  check_accum u_acc_rd (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(rec_start),
    .fold(fold_rd),
    .rev(is_bwd),
    .din(tape_in.data),
    .acc(acc_rd)
  );

  // Data read-back
  check_accum u_acc_rb (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(rec_start),
    .fold(fold_rb),
    .rev(is_bwd),
    .din(tape_in.data),
    .acc(acc_rb)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || rec_start) begin
      res_rd_q <= `TC_ACC_INIT;
    end else if (tape_res && is_6250) begin
      res_rd_q <= tape_in.data;
    end
  end

  // ****************************************
  // Write side outputs
  // ****************************************
  logic close_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      close_q <= 1'b0;
      residue_byte <= 8'h00;
      residue_valid <= 1'b0;
      check_byte <= 8'h00;
      check_valid <= 1'b0;
      group_check_character <= 8'h00;
      group_check_valid <= 1'b0;
    end else begin
      close_q <= wr_close && is_write && (is_6250 || is_nrzi9);
      residue_valid <= wr_close && is_write && (is_6250 || is_pe);
      if (wr_close && is_write) begin
        residue_byte <= acc_in;
      end
      check_valid <= close_q;
      if (close_q) begin
        check_byte <= acc_wr;
      end
      group_check_valid <= grp_end && is_write && is_6250;
      if (grp_end && is_write && is_6250) begin
        group_check_character <= acc_wr;
      end
    end
  end

  assign residue_record = is_6250;

  // ****************************************
  // Error evaluation and sense
  // ****************************************
  wire crc_bad = (is_6250 || is_nrzi9) && acc_rd != `TC_MATCH_PATTERN;
  wire res_bad_6250 = res_rd_q != acc_out;
  wire res_bad_rb = is_bwd ? acc_rb != `TC_MATCH_PATTERN : acc_rb != acc_out;
  wire res_bad = is_6250 ? res_bad_6250 : (is_pe || is_nrzi9) && res_bad_rb;
  wire [2:0] set_vec;
  assign set_vec[`TC_ST_CRC] = rec_end && active && crc_bad;
  assign set_vec[`TC_ST_RESIDUE] = rec_end && active && res_bad;
  assign set_vec[`TC_ST_BUFCMP] = buf_empty && active && acc_in != acc_out;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~clr_bits) | set_vec;
    end
  end

  assign sense.s3_b3 = status_q[`TC_ST_CRC];
  assign sense.s9_b3 = status_q[`TC_ST_RESIDUE];
  assign sense.s3_b7 = status_q[`TC_ST_BUFCMP];
  assign sense.s9_b2 = status_q[`TC_ST_BUFCMP];
  assign irq = |(status_q & irq_en_q);

  // ****************************************
  // Read data
  // ****************************************
  wire [31:0] rd_word =
    araddr == `TC_ADDR_CTRL ? {28'h0, ctrl_q} :
    araddr == `TC_ADDR_STATUS ? {29'h0, status_q} :
    araddr == `TC_ADDR_IRQ_EN ? {29'h0, irq_en_q} :
    araddr == `TC_ADDR_ACCUM ? {res_rd_q, acc_rb, acc_out, acc_in} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `TC_RESP_OKAY;
    end else if (do_read) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence close_s;
    wr_close && is_write && is_6250;
  endsequence

  sequence check_out_s;
    !check_valid ##1 check_valid;
  endsequence

  record_check_seq_a: assert property (close_s |=> residue_valid ##0 check_out_s)
    else $error("check byte not emitted two cycles after close");
  residue_fold_a: assert property (close_s |=> residue_byte == $past(acc_in) && residue_valid)
    else $error("residue byte not taken from input accumulator");
  pe_no_record_a: assert property (is_pe |-> !residue_record)
    else $error("phase-encoded residue marked for recording");
  bufcmp_set_a: assert property (buf_empty && active && acc_in != acc_out |=> sense.s3_b7 && sense.s9_b2)
    else $error("buffer compare mismatch not reported");
  nrzi7_quiet_a: assert property (!active && !wr_clr |=> $stable(status_q))
    else $error("seven-track mode raised a check error");
  group_char_a: assert property (grp_end && is_write && is_6250 |=> group_check_valid && group_check_character == $past(acc_wr))
    else $error("group check character missing or wrong");
  start_clear_a: assert property (rec_start |=> acc_in == `TC_ACC_INIT && acc_out == `TC_ACC_INIT && acc_rd == `TC_ACC_INIT)
    else $error("accumulators not cleared at record start");
  residue_capture_a: assert property (tape_res && is_6250 && !rec_start |=> res_rd_q == $past(tape_in.data))
    else $error("read residue not captured");
  set_wins_a: assert property (rec_end && active && crc_bad |=> sense.s3_b3)
    else $error("record check failure lost");
  irq_level_a: assert property ($rose(irq) |-> $past(|set_vec) || $past(wr_en))
    else $error("interrupt rose without a new event or enable");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before handshake");
endmodule

// ### tape_check_consts.svh
// Offsets, field positions and reset values of the check accumulator block
`ifndef TAPE_CHECK_CONSTS_SVH
`define TAPE_CHECK_CONSTS_SVH
`define TC_ADDR_CTRL 8'h00
`define TC_ADDR_STATUS 8'h04
`define TC_ADDR_IRQ_CLR 8'h08
`define TC_ADDR_IRQ_EN 8'h0c
`define TC_ADDR_ACCUM 8'h10
`define TC_CTRL_MODE_LSB 0
`define TC_CTRL_OP_LSB 2
`define TC_CTRL_RESET 4'h0
`define TC_ST_CRC 0
`define TC_ST_RESIDUE 1
`define TC_ST_BUFCMP 2
`define TC_ACC_INIT 8'h00
`define TC_MATCH_PATTERN 8'h00
`define TC_POLY 8'h07
`define TC_RESP_OKAY 2'b00
`define TC_RESP_SLVERR 2'b10
`endif

// ### tape_check_pkg.sv
// Types shared by the check accumulator block
package tape_check_pkg;
  typedef enum logic [1:0] {MODE_6250, MODE_PE, MODE_NRZI9, MODE_NRZI7} mode_t;
  typedef enum logic [1:0] {OP_WRITE, OP_READ_FWD, OP_READ_BWD, OP_IDLE} op_t;
  typedef enum logic [1:0] {KIND_DATA, KIND_RESIDUE, KIND_CHECK, KIND_OTHER} kind_t;
  typedef struct packed {
    logic valid;
    kind_t kind;
    logic [7:0] data;
  } tape_byte_t;
  typedef struct packed {
    logic s3_b3;
    logic s3_b7;
    logic s9_b2;
    logic s9_b3;
  } sense_t;
endpackage

// ### check_accum.sv
// One cyclic check accumulator, folding a byte per strobe
`timescale 1ns/100ps
`include "tape_check_consts.svh"
module check_accum #(
  parameter int W = 8,
  parameter logic [W-1:0] POLY = `TC_POLY
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  input wire logic fold,
  input wire logic rev,
  input wire logic [W-1:0] din,
  output logic [W-1:0] acc
);
  logic [W-1:0] acc_q;
  logic [W-1:0] acc_d;
  logic [W-1:0] poly_rev;
  logic [W-1:0] nxt;

  // Reflected polynomial for bytes that arrive in reverse order
  always_comb begin
    for (int i = 0; i < W; i++) begin
      poly_rev[i] = POLY[W-1-i];
    end
  end

  always_comb begin
    nxt = acc_q ^ din;
    for (int i = 0; i < W; i++) begin
      if (rev) begin
        nxt = nxt[0] ? ((nxt >> 1) ^ poly_rev) : (nxt >> 1);
      end else begin
        nxt = nxt[W-1] ? ((nxt << 1) ^ POLY) : (nxt << 1);
      end
    end
  end

  assign acc_d = clr ? W'(`TC_ACC_INIT) : (fold ? nxt : acc_q);
  assign acc = acc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= W'(`TC_ACC_INIT);
    end else begin
      acc_q <= acc_d;
    end
  end
endmodule

// ### tape_side_model.sv
// Far-side model: channel bus, write section and tape read data
`timescale 1ns/100ps
module tape_side_model (
  input wire logic aclk,
  output logic buf_in_valid,
  output logic [7:0] buf_in_byte,
  output logic buf_out_valid,
  output logic [7:0] buf_out_byte,
  output tape_check_pkg::tape_byte_t tape_in
);
  initial begin
    {buf_in_valid, buf_out_valid} = 2'b00;
    {buf_in_byte, buf_out_byte} = 16'h0000;
    tape_in = '0;
  end
  // ****************************************
  // One byte per strobe, released lines invert
  // ****************************************
  task automatic push(input logic [2:0] sel, input logic [1:0] k, input logic [7:0] bi,
                      input logic [7:0] bo);
    @(posedge aclk);
    buf_in_valid <= sel[0];
    buf_in_byte <= bi;
    buf_out_valid <= sel[1];
    buf_out_byte <= bo;
    tape_in <= {sel[2], k, bi};
    @(posedge aclk);
    buf_in_valid <= 1'b0;
    buf_in_byte <= ~bi;
    buf_out_valid <= 1'b0;
    buf_out_byte <= ~bo;
    tape_in <= {1'b0, k, ~bi};
  endtask
endmodule

// ### tape_data_path_check_accumulators_tb.sv
// Self-checking bench of the tape check accumulators
`timescale 1ns/100ps
`include "tape_check_consts.svh"
module tape_data_path_check_accumulators_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, residue_byte, check_byte, group_check_character;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [4:0] ctl;
  logic residue_valid, residue_record, check_valid, group_check_valid, irq;
  logic buf_in_valid, buf_out_valid;
  logic [7:0] buf_in_byte, buf_out_byte, ein, eout, c;
  tape_check_pkg::tape_byte_t tape_in;
  tape_check_pkg::sense_t sense;
  logic [15:0] st = 16'h432a;
  logic [7:0] q[$];
  int n_fail = 0;
  int tests_run = 0;
  wire [2:0] pulses = {group_check_valid, check_valid, residue_valid};

  always #50 aclk = ~aclk;

  tape_check_top dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .rec_start(ctl[0]), .buf_in_valid, .buf_in_byte, .buf_out_valid, .buf_out_byte,
    .buf_empty(ctl[1]), .grp_end(ctl[2]), .wr_close(ctl[3]), .tape_in, .rec_end(ctl[4]),
    .residue_byte, .residue_valid, .residue_record, .check_byte, .check_valid,
    .group_check_character, .group_check_valid, .sense, .irq
  );
  tape_side_model m (
    .aclk, .buf_in_valid, .buf_in_byte, .buf_out_valid, .buf_out_byte, .tape_in
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] crc(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    x = a ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? ({x[6:0], 1'b0} ^ `TC_POLY) : {x[6:0], 1'b0};
    return x;
  endfunction
  // Reverse-order fold for backward reads
  function automatic logic [7:0] crc_r(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic [7:0] p;
    logic [7:0] pr;
    p = `TC_POLY;
    for (int i = 0; i < 8; i++) pr[i] = p[7 - i];
    x = a ^ d;
    for (int i = 0; i < 8; i++) x = x[0] ? ({1'b0, x[7:1]} ^ pr) : {1'b0, x[7:1]};
    return x;
  endfunction
  function automatic logic [7:0] rnd();
    st = {st[14:0], st[15] ^ st[13] ^ st[12] ^ st[10]};
    return st[7:0];
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 50) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit done;
    n = 0;
    done = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    while (!done && n < 50) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      // Late ready leaves the response waiting for a cycle
      if (n == 2) bready <= 1'b1;
      if (bvalid && bready) begin
        done = 1;
        bready <= 1'b0;
        chk("bresp", er, bresp);
      end
      n++;
    end
    bound(done ? 0 : n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    bit done;
    n = 0;
    done = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1;
        rready <= 1'b0;
        chk("rdata", exp, rdata);
        chk("rresp", er, rresp);
      end
      n++;
    end
    bound(n);
  endtask
  task automatic strobe(input int k);
    @(posedge aclk);
    ctl[k] <= 1'b1;
    @(posedge aclk);
    ctl[k] <= 1'b0;
  endtask
  task automatic wait_hi(input int k);
    int n;
    for (n = 0; n < 50; n++) begin
      #1;
      if (pulses[k] === 1'b1) break;
      @(posedge aclk);
    end
    bound(n);
  endtask
  task automatic sense_is(input logic [3:0] e);
    #1;
    chk("sense", {28'h0, e}, {28'h0, sense});
  endtask
  // Mode and op held for the whole record, then accumulators cleared
  task automatic start(input logic [1:0] md, input logic [1:0] op);
    wr(`TC_ADDR_IRQ_CLR, 32'h7, `TC_RESP_OKAY);
    wr(`TC_ADDR_CTRL, {28'h0, op, md}, `TC_RESP_OKAY);
    strobe(0);
    ein = `TC_ACC_INIT;
    eout = `TC_ACC_INIT;
    q.delete();
  endtask
  task automatic fill(input int nb, input logic [2:0] sel, input logic [7:0] flip);
    logic [7:0] b;
    logic [7:0] bo;
    for (int i = 0; i < nb; i++) begin
      b = rnd();
      bo = (i == nb - 1) ? b ^ flip : b;
      q.push_back(bo);
      ein = crc(ein, b);
      eout = crc(eout, bo);
      m.push(sel, 2'd0, b, bo);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb, ctl} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TC_ADDR_CTRL, `TC_CTRL_RESET, `TC_RESP_OKAY);
    rd(`TC_ADDR_STATUS, 32'h0, `TC_RESP_OKAY);
    rd(`TC_ADDR_IRQ_EN, 32'h0, `TC_RESP_OKAY);
    rd(8'h20, 32'h0, `TC_RESP_SLVERR);
    wr(8'h20, 32'h7, `TC_RESP_SLVERR);
    wr(`TC_ADDR_STATUS, 32'h7, `TC_RESP_SLVERR);
    wr(`TC_ADDR_IRQ_EN, 32'h7, `TC_RESP_OKAY);
    // Write at 6250: residue, group character, record check byte
    start(2'd0, 2'd0);
    fill(6, 3'b011, 8'h00);
    c = `TC_ACC_INIT;
    foreach (q[i]) c = crc(c, q[i]);
    strobe(2);
    wait_hi(2);
    chk("group", c, group_check_character);
    strobe(1);
    sense_is(4'b0000);
    strobe(3);
    wait_hi(0);
    chk("residue", ein, residue_byte);
    chk("record", 1, residue_record);
    c = crc(c, ein);
    wait_hi(1);
    chk("check", c, check_byte);
    // Phase-encoded write with a dropped bit across the buffer
    start(2'd1, 2'd0);
    fill(4, 3'b011, 8'h10);
    strobe(1);
    sense_is(4'b0110);
    chk("irq", 1, irq);
    rd(`TC_ADDR_STATUS, 32'h4, `TC_RESP_OKAY);
    wr(`TC_ADDR_IRQ_EN, 32'h0, `TC_RESP_OKAY);
    chk("irq", 0, irq);
    wr(`TC_ADDR_IRQ_EN, 32'h7, `TC_RESP_OKAY);
    chk("irq", 1, irq);
    strobe(3);
    wait_hi(0);
    chk("residue", ein, residue_byte);
    chk("record", 0, residue_record);
    wr(`TC_ADDR_IRQ_CLR, 32'h7, `TC_RESP_OKAY);
    chk("irq", 0, irq);
    rd(`TC_ADDR_STATUS, 32'h0, `TC_RESP_OKAY);
    // Nine-track write: check byte over data only
    start(2'd2, 2'd0);
    fill(5, 3'b011, 8'h00);
    strobe(3);
    wait_hi(1);
    chk("check", ein, check_byte);
    rd(`TC_ADDR_ACCUM, {16'h0000, ein, ein}, `TC_RESP_OKAY);
    // Nine-track forward read, good and corrupt check byte
    for (int bad = 0; bad < 2; bad++) begin
      start(2'd2, 2'd1);
      fill(5, 3'b111, 8'h00);
      m.push(3'b100, 2'd2, ein ^ bad[7:0], 8'h00);
      strobe(4);
      sense_is(bad ? 4'b1000 : 4'b0000);
    end
    // Phase-encoded forward read with a bit lost toward the channel
    start(2'd1, 2'd1);
    fill(4, 3'b111, 8'h01);
    strobe(4);
    sense_is(4'b0001);
    strobe(1);
    sense_is(4'b0111);
    // Read at 6250 both ways, good and corrupt residue; check byte as the writer builds it
    for (int t = 0; t < 4; t++) begin
      start(2'd0, t[1] ? 2'd2 : 2'd1);
      fill(4, 3'b111, 8'h00);
      c = `TC_ACC_INIT;
      foreach (q[i]) c = t[1] ? crc_r(c, q[i]) : crc(c, q[i]);
      m.push(3'b100, 2'd1, c ^ {t[0], 7'h00}, 8'h00);
      m.push(3'b100, 2'd2, t[1] ? crc_r(c, c) : crc(c, c), 8'h00);
      strobe(4);
      sense_is(t[0] ? 4'b1001 : 4'b0000);
    end
    // Phase-encoded backward read: data and check bytes close to the match pattern
    for (int bad = 0; bad < 2; bad++) begin
      start(2'd1, 2'd2);
      fill(4, 3'b100, 8'h00);
      c = `TC_ACC_INIT;
      foreach (q[i]) c = crc_r(c, q[i]);
      m.push(3'b100, 2'd2, c ^ bad[7:0], 8'h00);
      strobe(4);
      sense_is(bad ? 4'b0001 : 4'b0000);
    end
    // Seven-track: nothing is checked at all
    start(2'd3, 2'd0);
    fill(4, 3'b111, 8'hff);
    m.push(3'b100, 2'd2, 8'h5a, 8'h00);
    strobe(1);
    strobe(4);
    strobe(3);
    sense_is(4'b0000);
    chk("irq", 0, irq);
    wrap_up();
  end
endmodule
